// file: hw/pim_pkg.sv
// Package: constants, types and register map of the process image mapper
package pim_pkg;

  // ************************************************************
  // Register map (word addresses, one word each)
  // ************************************************************
  localparam logic [5:0] ADDR_CTRL     = 6'h00;
  localparam logic [5:0] ADDR_STATUS   = 6'h01;
  localparam logic [5:0] ADDR_IRQ_STAT = 6'h02;
  localparam logic [5:0] ADDR_IRQ_MASK = 6'h03;
  localparam logic [5:0] ADDR_KEY_IMG  = 6'h04;
  localparam logic [5:0] ADDR_DIN_IMG  = 6'h05;
  localparam logic [5:0] ADDR_SAFE_IN  = 6'h06;
  localparam logic [5:0] ADDR_LED_R    = 6'h07;
  localparam logic [5:0] ADDR_LED_G    = 6'h08;
  localparam logic [5:0] ADDR_LED_B    = 6'h09;
  localparam logic [5:0] ADDR_DOUT     = 6'h0a;
  localparam logic [5:0] ADDR_SAFE_MAP = 6'h0b;
  localparam logic [5:0] ADDR_XCHG     = 6'h0c;

  // ************************************************************
  // Field layout and reset values
  // ************************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_START_LSB = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam int SAFE_IN_BYTES = 5;
  localparam int SAFE_OUT_BYTES = 4;
  localparam int SENSOR_BIT_A = 4;
  localparam int SENSOR_BIT_B = 5;
  localparam int ESTOP_BIT = 0;
  localparam int IRQ_XCHG = 0;
  localparam int IRQ_ESTOP = 1;
  localparam int IRQ_MODE = 2;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Safety evaluation modes
  typedef enum logic [1:0] {
    MODE_NONE   = 2'h0,
    MODE_SENSOR = 2'h1,
    MODE_ESTOP  = 2'h2
  } safe_mode_e;

  // LED colour decode
  typedef enum logic [2:0] {
    LED_OFF    = 3'h0,
    LED_RED    = 3'h1,
    LED_GREEN  = 3'h2,
    LED_BLUE   = 3'h3,
    LED_YELLOW = 3'h4,
    LED_WHITE  = 3'h5
  } led_colour_e;

  // Bus request carrier
  typedef struct packed {
    logic        read;
    logic        write;
    logic [5:0]  address;
    logic [31:0] writedata;
  } bus_req_s;

  // Fail-safe input byte and placement
  typedef struct packed {
    logic [7:0] start_addr;
    logic [7:0] state_byte;
  } safe_img_s;

endpackage : pim_pkg

// file: hw/pim_mapper.sv
// Process image mapper: keys, inputs, safety byte, LEDs and outputs
//
// Contract
// [R1] Safe channels use five input and four output bytes from start address
// [R2] First safe input byte reports sensor or stop-button state
// [R3] Other safe bytes carry protocol only, never user data
// [R4] Bits unused by the selected mode read zero
// [R5] With no mode configured nothing is evaluated
// [R6] Sensor mode: bits 4 and 5 are contacts, 1 closed
// [R7] Stop mode: bit 0 is 0 pressed or error, 1 released
// [R8] Inputs reserved for safe channels leave the standard image
// [R9] Standard image kept separate from safe channel state
// [R10] Keys 0..31 fill two bytes per slot, slots 1 and 2
// [R11] Inputs 0..31 fill two bytes per slot, slots 3 and 4
// [R12] LED colour from same bit in red, green, blue bytes
// [R13] Six LED bytes per slot, two groups of eight LEDs
// [R14] Outputs 16..31 from two slot 4 bytes, lowest at bit 0
// [R15] Images refresh once per exchange; outputs hold between
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pim_mapper
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // Avalon-MM slave
  input  wire pim_pkg::bus_req_s bus_req,
  output logic [31:0]            readdata,
  output logic                   waitrequest,
  output logic                   irq,
  // Panel side
  input  wire logic [31:0]       key_state,
  input  wire logic [31:0]       input_pin_bit,
  input  wire logic              safe_channel_0,
  input  wire logic              safe_channel_1,
  input  wire logic              xchg_strobe,
  // Outputs to the panel
  output logic [31:0]            led_red,
  output logic [31:0]            led_green,
  output logic [31:0]            led_blue,
  output logic [15:0]            dout_hi,
  output logic [7:0]             safe_image,
  output logic [7:0]             safe_start
);
  import pim_pkg::*;

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic led_colour_e led_decode(input logic r, input logic g,
                                             input logic b);
    unique case ({r, g, b})
      3'b100:  led_decode = LED_RED;
      3'b010:  led_decode = LED_GREEN;
      3'b001:  led_decode = LED_BLUE;
      3'b110:  led_decode = LED_YELLOW;
      3'b111:  led_decode = LED_WHITE;
      default: led_decode = LED_OFF;
    endcase
  endfunction : led_decode

  // Byte idx of an image holds items 8*idx .. +7
  function automatic logic [7:0] slot_byte(input logic [31:0] v,
                                           input logic [1:0] idx);
    slot_byte = v[idx*8 +: 8];
  endfunction : slot_byte

  // ************************************************************
  // State
  // ************************************************************
  logic [31:0] ctrl_q;
  logic [31:0] irq_stat_q;
  logic [31:0] irq_mask_q;
  logic [31:0] key_img_q;
  logic [31:0] din_img_q;
  logic [31:0] led_r_img_q;
  logic [31:0] led_g_img_q;
  logic [31:0] led_b_img_q;
  logic [15:0] dout_img_q;
  logic [31:0] led_r_sh_q;
  logic [31:0] led_g_sh_q;
  logic [31:0] led_b_sh_q;
  logic [15:0] dout_sh_q;
  safe_img_s   safe_q;
  logic        estop_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  safe_mode_e  mode_q;
  logic [7:0]  safe_byte_d;
  logic [31:0] din_masked;
  logic [31:0] irq_set;
  logic        wr_en;
  logic        rd_en;

  assign wr_en = bus_req.write && ack_q;
  assign rd_en = bus_req.read && !ack_q;

  // ************************************************************
  // Bus slave: one wait cycle, then acknowledge
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= (bus_req.read || bus_req.write) && !ack_q;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl_q      <= CTRL_RESET;
      irq_mask_q  <= MASK_RESET;
      led_r_sh_q  <= '0;
      led_g_sh_q  <= '0;
      led_b_sh_q  <= '0;
      dout_sh_q   <= '0;
    end else if (wr_en) begin
      unique case (bus_req.address)
        ADDR_CTRL:     ctrl_q <= bus_req.writedata;
        ADDR_IRQ_MASK: irq_mask_q <= bus_req.writedata;
        ADDR_LED_R:    led_r_sh_q <= bus_req.writedata;
        ADDR_LED_G:    led_g_sh_q <= bus_req.writedata;
        ADDR_LED_B:    led_b_sh_q <= bus_req.writedata;
        ADDR_DOUT:     dout_sh_q <= bus_req.writedata[15:0];
        default: ;
      endcase
    end
  end
  always_comb begin
    unique case (ctrl_q[CTRL_MODE_LSB +: 2])
      2'h1:    mode_q = MODE_SENSOR;
      2'h2:    mode_q = MODE_ESTOP;
      default: mode_q = MODE_NONE;
    endcase
  end

  // ************************************************************
  // Safe channel byte
  // ************************************************************
  // [R5] No evaluation
  // [R6] Sensor contacts
  // [R7] Stop button state
  // [R4] Unused bits zero
  always_comb begin
    safe_byte_d = BYTE_ZERO;
    unique case (mode_q)
      MODE_SENSOR: begin
        safe_byte_d[SENSOR_BIT_A] = safe_channel_0;
        safe_byte_d[SENSOR_BIT_B] = safe_channel_1;
      end
      // A single open or mismatched channel counts as pressed or error
      MODE_ESTOP: safe_byte_d[ESTOP_BIT] = safe_channel_0 && safe_channel_1;
      default: ;
    endcase
  end

  // [R8] Reserved inputs removed
  // Safe channels sit on the top two pins of the upper connector
  always_comb begin
    din_masked = input_pin_bit;
    if (mode_q != MODE_NONE) begin
      din_masked[31:30] = 2'b00;
    end
  end

  // ************************************************************
  // Cyclic exchange
  // ************************************************************
  // [R15] Refresh per exchange
  // [R9] Separate images
  // [R10] Key image
  // [R11] Input image
  // [R1] Start address
  // [R2] First safe byte
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      key_img_q   <= '0;
      din_img_q   <= '0;
      led_r_img_q <= '0;
      led_g_img_q <= '0;
      led_b_img_q <= '0;
      dout_img_q  <= '0;
      safe_q      <= '0;
    end else if (xchg_strobe) begin
      key_img_q   <= key_state;
      din_img_q   <= din_masked;
      led_r_img_q <= led_r_sh_q;
      led_g_img_q <= led_g_sh_q;
      led_b_img_q <= led_b_sh_q;
      dout_img_q  <= dout_sh_q;
      safe_q.start_addr <= ctrl_q[CTRL_START_LSB +: 8];
      safe_q.state_byte <= safe_byte_d;
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      estop_q <= 1'b0;
    end else begin
      estop_q <= (mode_q == MODE_ESTOP) && !safe_byte_d[ESTOP_BIT];
    end
  end
  always_comb begin
    irq_set = '0;
    irq_set[IRQ_XCHG] = xchg_strobe;
    irq_set[IRQ_ESTOP] = (mode_q == MODE_ESTOP) && !safe_byte_d[ESTOP_BIT]
                         && !estop_q;
    irq_set[IRQ_MODE] = wr_en && (bus_req.address == ADDR_CTRL);
  end

  // Set wins over a same-cycle write-one clear
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr_en &&
                    bus_req.address == ADDR_IRQ_STAT) ?
                    bus_req.writedata : 32'h0000_0000)) | irq_set;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************
  always_comb begin
    rdata_q = UNMAPPED_READ;
    unique case (bus_req.address)
      ADDR_CTRL:     rdata_q = ctrl_q;
      ADDR_STATUS:   rdata_q = {29'h0, led_decode(led_r_img_q[0],
                                 led_g_img_q[0], led_b_img_q[0])};
      ADDR_IRQ_STAT: rdata_q = irq_stat_q;
      ADDR_IRQ_MASK: rdata_q = irq_mask_q;
      ADDR_KEY_IMG:  rdata_q = key_img_q;
      ADDR_DIN_IMG:  rdata_q = din_img_q;
      // [R3] Protocol bytes stay out of user data
      ADDR_SAFE_IN:  rdata_q = {24'h0, safe_q.state_byte};
      ADDR_LED_R:    rdata_q = led_r_sh_q;
      ADDR_LED_G:    rdata_q = led_g_sh_q;
      ADDR_LED_B:    rdata_q = led_b_sh_q;
      ADDR_DOUT:     rdata_q = {16'h0, dout_sh_q};
      ADDR_SAFE_MAP: rdata_q = {8'h0, 8'(SAFE_OUT_BYTES),
                                8'(SAFE_IN_BYTES), safe_q.start_addr};
      ADDR_XCHG:     rdata_q = {slot_byte(key_img_q, 2'h1),
                                slot_byte(key_img_q, 2'h0),
                                slot_byte(din_img_q, 2'h1),
                                slot_byte(din_img_q, 2'h0)};
      default:       rdata_q = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      readdata <= '0;
    end else if (rd_en) begin
      readdata <= rdata_q;
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      waitrequest <= 1'b1;
    end else begin
      waitrequest <= !((bus_req.read || bus_req.write) && !ack_q);
    end
  end

  // ************************************************************
  // Panel outputs
  // ************************************************************
  // [R12] Colour bytes per LED
  // [R13] Six bytes per slot
  // [R14] Outputs 16 to 31
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      led_red    <= '0;
      led_green  <= '0;
      led_blue   <= '0;
      dout_hi    <= '0;
      safe_image <= '0;
      safe_start <= '0;
    end else begin
      led_red    <= led_r_img_q;
      led_green  <= led_g_img_q;
      led_blue   <= led_b_img_q;
      dout_hi    <= dout_img_q;
      safe_image <= safe_q.state_byte;
      safe_start <= safe_q.start_addr;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_unused_zero: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    (safe_byte_d & ~((mode_q == MODE_SENSOR) ? 8'h30 :
      ((mode_q == MODE_ESTOP) ? 8'h01 : 8'h00))) == BYTE_ZERO)
    else $error("unused safe bit set");
  a_sensor_bits: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    (xchg_strobe && mode_q == MODE_SENSOR) |=> safe_q.state_byte ==
      {2'b00, $past(safe_channel_1), $past(safe_channel_0), 4'h0})
    else $error("sensor bits wrong");
  a_estop_bit: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (xchg_strobe && mode_q == MODE_ESTOP && !safe_channel_0) |=>
      !safe_q.state_byte[ESTOP_BIT])
    else $error("stop bit set while pressed");
  a_none_idle: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    (xchg_strobe && mode_q == MODE_NONE) |=> ##1 safe_image == 8'h00)
    else $error("evaluation with no mode");
  a_key_image: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    xchg_strobe |=> key_img_q == $past(key_state))
    else $error("key image not refreshed");
  a_din_reserved: assert property (@(posedge sys_clk) disable iff (rst) // [R8]
    (xchg_strobe && mode_q != MODE_NONE) |=> din_img_q[31:30] == 2'b00)
    else $error("reserved input in image");
  a_led_hold: assert property (@(posedge sys_clk) disable iff (rst) // [R15]
    !xchg_strobe |=> led_r_img_q == $past(led_r_img_q))
    else $error("LED image changed between exchanges");
  a_dout_follow: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
    xchg_strobe |=> ##1 dout_hi == $past(dout_sh_q, 2))
    else $error("outputs not applied");
  a_din_image: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    (xchg_strobe && mode_q == MODE_NONE) |=>
      din_img_q == $past(input_pin_bit))
    else $error("input image wrong");
  c_sensor: cover property (@(posedge sys_clk) disable iff (rst)
    xchg_strobe && mode_q == MODE_SENSOR);
  c_estop: cover property (@(posedge sys_clk) disable iff (rst)
    irq_set[IRQ_ESTOP]);
  c_irq: cover property (@(posedge sys_clk) disable iff (rst) irq);

endmodule : pim_mapper
`default_nettype wire

// file: testbench/plc_model.sv
// Controller model: one cyclic exchange strobe per bench request
`timescale 1ns/1ps
`default_nettype none
module plc_model (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // Exchange request from the bench
  input  wire logic cycle_req,
  // Exchange strobe to the panel
  output logic      xchg_strobe
);
  logic req_q;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      req_q       <= 1'b0;
      xchg_strobe <= 1'b0;
    end else begin
      req_q       <= cycle_req;
      // Edge detect: a held request must not smear into extra exchanges
      xchg_strobe <= cycle_req & ~req_q;
    end
  end
endmodule : plc_model
`default_nettype wire

// file: testbench/tb_top.sv
// Testbench: drives the mapper over its bus and panel pins
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pim_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst;
  bus_req_s    bus_req;
  logic [31:0] readdata;
  logic        waitrequest;
  logic        irq;
  logic [31:0] key_state;
  logic [31:0] input_pin_bit;
  logic        safe_channel_0;
  logic        safe_channel_1;
  logic        cycle_req;
  logic        xchg_strobe;
  logic [31:0] led_red;
  logic [31:0] led_green;
  logic [31:0] led_blue;
  logic [15:0] dout_hi;
  logic [7:0]  safe_image;
  logic [7:0]  safe_start;
  int          fail_count = 0;
  int          checks_done = 0;
  localparam led_colour_e colour_of [8] = '{LED_OFF, LED_BLUE, LED_GREEN,
    LED_OFF, LED_RED, LED_OFF, LED_YELLOW, LED_WHITE};

  pim_mapper DUT (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .key_state(key_state), .input_pin_bit(input_pin_bit),
    .safe_channel_0(safe_channel_0), .safe_channel_1(safe_channel_1),
    .xchg_strobe(xchg_strobe), .led_red(led_red), .led_green(led_green),
    .led_blue(led_blue), .dout_hi(dout_hi), .safe_image(safe_image),
    .safe_start(safe_start));
  plc_model partner (.sys_clk(sys_clk), .rst(rst), .cycle_req(cycle_req),
    .xchg_strobe(xchg_strobe));

  always #4 sys_clk = ~sys_clk;

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Request held until waitrequest is seen low; no latency assumed
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge sys_clk);
    bus_req <= '{~w, w, a, d};
    do begin
      @(posedge sys_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n == 50) chk("bus_answer", 32'h0, 32'h1);
    q = readdata;
    bus_req <= '0;
  endtask : bus

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdchk(input string nm, input logic [5:0] a,
                       input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rdchk

  task automatic pins(input logic [31:0] k, input logic [31:0] p,
                      input logic [1:0] c);
    @(posedge sys_clk);
    key_state      <= k;
    input_pin_bit  <= p;
    safe_channel_0 <= c[0];
    safe_channel_1 <= c[1];
  endtask : pins

  // Panel outputs land two cycles after the strobe; wait past that
  task automatic xchg();
    @(posedge sys_clk);
    cycle_req <= 1'b1;
    @(posedge sys_clk);
    cycle_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : xchg

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    @(negedge sys_clk);
    chk("waitrequest", 32'h1, {31'h0, waitrequest});
    chk("safe_idle", 32'h0, {24'h0, safe_image});
    rdchk("ctrl", ADDR_CTRL, CTRL_RESET);
    rdchk("mask", ADDR_IRQ_MASK, MASK_RESET);
    rdchk("unmapped", 6'h3f, UNMAPPED_READ);
  endtask : t_reset

  task automatic t_keys();
    logic [31:0] k;
    logic [31:0] p;
    k = 32'ha5c3_0f96;
    p = 32'hc0de_1234;
    pins(k, p, 2'h3);
    xchg();
    rdchk("key_img", ADDR_KEY_IMG, k);
    rdchk("din_img", ADDR_DIN_IMG, p);
    rdchk("slot_bytes", ADDR_XCHG, {k[15:0], p[15:0]});
    pins(~k, p, 2'h0);
    rdchk("key_held", ADDR_KEY_IMG, k);
    wr(ADDR_CTRL, 32'h1);
    pins(k, p, 2'h0);
    xchg();
    rdchk("din_reserved", ADDR_DIN_IMG, p & 32'h3fff_ffff);
    rdchk("key_kept", ADDR_KEY_IMG, k);
  endtask : t_keys

  task automatic t_safe();
    logic [7:0] e;
    logic [7:0] x;
    for (int m = 0; m < 3; m++) begin
      x = 8'h40 + 8'(m);
      wr(ADDR_CTRL, {16'h0, x, 6'h0, 2'(m)});
      for (int c = 0; c < 4; c++) begin
        pins(32'h0, 32'h0, 2'(c));
        xchg();
        e = (m == 1) ? {2'h0, 2'(c), 4'h0} : {7'h0, (m == 2) && (c == 3)};
        chk("safe_image", {24'h0, e}, {24'h0, safe_image});
        chk("safe_start", {24'h0, x}, {24'h0, safe_start});
        rdchk("safe_in", ADDR_SAFE_IN, {24'h0, e});
      end
      rdchk("safe_map", ADDR_SAFE_MAP, {24'h00_0405, x});
    end
  endtask : t_safe

  task automatic t_led();
    logic [31:0] r;
    for (int p = 0; p < 8; p++) begin
      r = 32'h8001_0100 | 32'(p[2]);
      wr(ADDR_LED_R, r);
      wr(ADDR_LED_G, 32'h4002_0200 | 32'(p[1]));
      wr(ADDR_LED_B, 32'h2004_0400 | 32'(p[0]));
      xchg();
      chk("led_red", r, led_red);
      chk("led_green", 32'h4002_0200 | 32'(p[1]), led_green);
      chk("led_blue", 32'h2004_0400 | 32'(p[0]), led_blue);
      rdchk("colour", ADDR_STATUS, {29'h0, colour_of[p]});
    end
    wr(ADDR_LED_R, 32'h0);
    @(negedge sys_clk);
    chk("led_held", r, led_red);
    wr(ADDR_DOUT, 32'h0000_8001);
    xchg();
    chk("dout_hi", 32'h8001, {16'h0, dout_hi});
  endtask : t_led

  task automatic t_irq();
    wr(ADDR_CTRL, 32'h0);
    rdchk("irq_events", ADDR_IRQ_STAT, 32'h7);
    wr(ADDR_IRQ_STAT, 32'h7);
    rdchk("irq_clear", ADDR_IRQ_STAT, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1 << IRQ_XCHG);
    xchg();
    chk("irq_up", 32'h1, {31'h0, irq});
    wr(ADDR_IRQ_STAT, 32'h1 << IRQ_XCHG);
    repeat (2) @(negedge sys_clk);
    chk("irq_down", 32'h0, {31'h0, irq});
    wr(ADDR_IRQ_MASK, 32'h0);
    xchg();
    chk("irq_masked", 32'h0, {31'h0, irq});
    rdchk("irq_sticky", ADDR_IRQ_STAT, 32'h1 << IRQ_XCHG);
  endtask : t_irq

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude

  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    conclude();
  end

  initial begin
    rst = 1'b1;
    bus_req = '0;
    cycle_req = 1'b0;
    key_state = 32'h0;
    input_pin_bit = 32'h0;
    safe_channel_0 = 1'b0;
    safe_channel_1 = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    $display("reset test done");
    t_keys();
    $display("image test done");
    t_safe();
    $display("safe test done");
    t_led();
    $display("output test done");
    t_irq();
    $display("interrupt test done");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
